// File: core/tsarc_core.sv
// Purpose: Reset, address, command decode and conversion timing core
// Assumes: An external bus front end delivers decoded byte transfers
// Notes:   Converter values are sampled at the end of the conversion time
module tsarc_core #(
  parameter int unsigned CONV_CYC = tsarc_pkg::CONV_CYCLES,
  parameter int unsigned SLOW_CYC = tsarc_pkg::SLOW_PERIOD_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       supply_por_i,
  input  wire logic       adc_uvlo_i,
  input  wire logic       hw_standby_pin_n_i,
  input  wire logic [1:0] addr_select_a_i,
  input  wire logic [1:0] addr_select_b_i,
  input  wire logic [6:0] bus_addr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       cmd_send_i,
  input  wire logic       recv_i,
  input  wire logic       ara_rd_i,
  input  wire logic       bus_stop_i,
  input  wire logic [7:0] local_temp_i,
  input  wire logic [7:0] remote_temp_i,
  input  wire logic       diode_open_i,
  output logic      [7:0] reg_rdata_o,
  output logic      [6:0] target_addr_o,
  output logic            addr_hit_o,
  output logic            ara_hit_o,
  output logic            adc_start_o,
  output logic            converting_o,
  output logic            alert_o,
  output logic            alert_oe_o
);

  typedef struct packed {
    tsarc_pkg::tsarc_state_t         fsm;
    logic [31:0]                     rate_cnt;
    logic [31:0]                     conv_cnt;
    logic [7:0]                      pointer;
    logic [1:0]                      cfg;
    logic [tsarc_pkg::RATE_W-1:0]    rate;
    logic [7:0]                      lt;
    logic [7:0]                      rt;
    logic [7:0]                      lhi;
    logic [7:0]                      llo;
    logic [7:0]                      rhi;
    logic [7:0]                      rlo;
    logic [4:0]                      flags;
    logic                            alert;
    logic                            start_req;
    logic                            swrst_arm;
    logic                            hw_standby_pin_q;
    logic                            start_p;
    logic [7:0]                      rdata;
  } tsarc_core_t;

  localparam tsarc_core_t RST = '{
    fsm:       tsarc_pkg::ST_INIT,
    rate_cnt:  32'h0,
    conv_cnt:  32'h0,
    pointer:   tsarc_pkg::POINTER_POR,
    cfg:       2'h0,
    rate:      tsarc_pkg::RATE_POR,
    lt:        tsarc_pkg::TEMP_POR,
    rt:        tsarc_pkg::TEMP_POR,
    lhi:       tsarc_pkg::LIMIT_MAX,
    llo:       tsarc_pkg::LIMIT_MIN,
    rhi:       tsarc_pkg::LIMIT_MAX,
    rlo:       tsarc_pkg::LIMIT_MIN,
    flags:     5'h00,
    alert:     1'b0,
    start_req: 1'b0,
    swrst_arm: 1'b0,
    hw_standby_pin_q:    1'b0,
    start_p:   1'b0,
    rdata:     8'h00
  };

  tsarc_core_t st_reg;
  tsarc_core_t st_next;

  logic        hw_standby_pin;
  logic [31:0] period;
  logic        timer_hit;
  logic        conv_end;
  logic [4:0]  fset;
  logic [4:0]  persist;
  logic        rd_any;
  logic [7:0]  rd_addr;
  logic        status_rd;
  logic        one_shot;
  logic        sample;

  // Alarm conditions of a pair of results against the limits
  function automatic logic [4:0] alarms(input tsarc_core_t s, input logic [7:0] l,
                                        input logic [7:0] r, input logic open);
    return {tsarc_pkg::tsarc_above(l, s.lhi), tsarc_pkg::tsarc_above(s.llo, l),
            tsarc_pkg::tsarc_above(r, s.rhi), tsarc_pkg::tsarc_above(s.rlo, r),
            open};
  endfunction : alarms

  // Readback mux over the command index
  function automatic logic [7:0] reg_value(input tsarc_core_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      tsarc_pkg::CMD_LOCAL_TEMP:  v = s.lt;
      tsarc_pkg::CMD_REMOTE_TEMP: v = s.rt;
      tsarc_pkg::CMD_STATUS:      v = {(s.fsm == tsarc_pkg::ST_CONV), s.flags, 2'h0};
      tsarc_pkg::CMD_CFG_RD:      v = {s.cfg, 6'h00};
      tsarc_pkg::CMD_RATE_RD:     v = {5'h00, s.rate};
      tsarc_pkg::CMD_LHI_RD:      v = s.lhi;
      tsarc_pkg::CMD_LLO_RD:      v = s.llo;
      tsarc_pkg::CMD_RHI_RD:      v = s.rhi;
      tsarc_pkg::CMD_RLO_RD:      v = s.rlo;
      default:                    v = 8'h00;
    endcase
    return v;
  endfunction : reg_value

  // Strap sampling happens in the one init cycle after any reset
  assign sample = (st_reg.fsm == tsarc_pkg::ST_INIT);

  tsarc_addr_latch u_addr (
    .clock_i       (clock_i),
    .sys_rst_i     (sys_rst_i),
    .sample_i      (sample),
    .sel_a_i       (addr_select_a_i),
    .sel_b_i       (addr_select_b_i),
    .bus_addr_i    (bus_addr_i),
    .target_addr_o (target_addr_o),
    .addr_hit_o    (addr_hit_o)
  );

  // Shared decode terms
  always_comb begin
    hw_standby_pin      = st_reg.cfg[tsarc_pkg::CFG_HW_STANDBY_PIN_BIT] | ~hw_standby_pin_n_i;
    period    = SLOW_CYC >> st_reg.rate;
    timer_hit = (st_reg.rate_cnt >= period - 32'h2); // Start lands two cycles after the hit
    conv_end  = (st_reg.fsm == tsarc_pkg::ST_CONV) && (st_reg.conv_cnt >= CONV_CYC - 32'h1);
    fset      = conv_end ? alarms(st_reg, local_temp_i, remote_temp_i, diode_open_i) : 5'h00;
    persist   = alarms(st_reg, st_reg.lt, st_reg.rt, diode_open_i);
    rd_any    = reg_rd_i | recv_i;
    rd_addr   = reg_rd_i ? reg_addr_i : st_reg.pointer;
    status_rd = rd_any && (rd_addr == tsarc_pkg::CMD_STATUS);
    one_shot  = (cmd_send_i | reg_wr_i) && (reg_addr_i == tsarc_pkg::CMD_ONE_SHOT);
  end

  // Next-state logic for the whole core
  always_comb begin
    st_next         = st_reg;
    st_next.start_p = 1'b0;
    st_next.rdata   = 8'h00;
    st_next.hw_standby_pin_q  = hw_standby_pin;

    case (st_reg.fsm)
      tsarc_pkg::ST_INIT: begin
        // Standby held through reset parks the core without a first conversion
        st_next.fsm       = hw_standby_pin ? tsarc_pkg::ST_HW_STANDBY_PIN : tsarc_pkg::ST_IDLE;
        st_next.start_req = ~hw_standby_pin;
      end
      tsarc_pkg::ST_IDLE: begin
        if (timer_hit) begin
          st_next.start_req = 1'b1;
        end else begin
          st_next.rate_cnt = st_reg.rate_cnt + 32'h1;
        end
      end
      tsarc_pkg::ST_CONV: begin
        if (timer_hit) begin
          st_next.start_req = 1'b1; // Fastest rate chains back to back
        end else begin
          st_next.rate_cnt = st_reg.rate_cnt + 32'h1;
        end
        st_next.conv_cnt = st_reg.conv_cnt + 32'h1;
        if (conv_end) begin
          st_next.lt  = local_temp_i;
          st_next.rt  = remote_temp_i;
          st_next.fsm = hw_standby_pin ? tsarc_pkg::ST_HW_STANDBY_PIN : tsarc_pkg::ST_IDLE;
        end
      end
      tsarc_pkg::ST_HW_STANDBY_PIN: begin
        st_next.fsm = tsarc_pkg::ST_HW_STANDBY_PIN; // Timer frozen while stopped
      end
      default: begin
        st_next.fsm = tsarc_pkg::ST_INIT;
      end
    endcase

    // Standby edges: entering aborts at once, leaving starts one conversion
    if (hw_standby_pin && !st_reg.hw_standby_pin_q && st_reg.fsm != tsarc_pkg::ST_INIT) begin
      st_next.fsm       = tsarc_pkg::ST_HW_STANDBY_PIN;
      st_next.start_req = 1'b0;
    end else if (!hw_standby_pin && st_reg.hw_standby_pin_q) begin
      st_next.start_req = 1'b1;
      if (st_reg.fsm == tsarc_pkg::ST_HW_STANDBY_PIN) begin
        st_next.fsm = tsarc_pkg::ST_IDLE;
      end
    end

    // One-shot is dropped while busy so the running result is not disturbed
    if (one_shot && st_reg.fsm != tsarc_pkg::ST_CONV) begin
      st_next.start_req = 1'b1;
    end

    // Start a pending conversion once the converter has headroom
    if (st_reg.start_req && !adc_uvlo_i &&
        (st_reg.fsm == tsarc_pkg::ST_IDLE || st_reg.fsm == tsarc_pkg::ST_HW_STANDBY_PIN) &&
        st_next.fsm != tsarc_pkg::ST_INIT && !(hw_standby_pin && !st_reg.hw_standby_pin_q)) begin
      st_next.fsm       = tsarc_pkg::ST_CONV;
      st_next.conv_cnt  = 32'h0;
      st_next.rate_cnt  = 32'h0;
      st_next.start_req = 1'b0;
      st_next.start_p   = 1'b1;
    end

    // Pointer follows every command byte
    if (reg_wr_i || reg_rd_i || cmd_send_i) begin
      st_next.pointer = reg_addr_i;
    end

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        tsarc_pkg::CMD_CFG_WR:  st_next.cfg  = reg_wdata_i[tsarc_pkg::CFG_POS+:2];
        tsarc_pkg::CMD_RATE_WR: st_next.rate = reg_wdata_i[tsarc_pkg::RATE_W-1:0];
        tsarc_pkg::CMD_LHI_WR:  st_next.lhi  = reg_wdata_i;
        tsarc_pkg::CMD_LLO_WR:  st_next.llo  = reg_wdata_i;
        tsarc_pkg::CMD_RHI_WR:  st_next.rhi  = reg_wdata_i;
        tsarc_pkg::CMD_RLO_WR:  st_next.rlo  = reg_wdata_i;
        default:                st_next.cfg  = st_reg.cfg;
      endcase
    end

    // Reads; a status read keeps only conditions still present
    if (rd_any) begin
      st_next.rdata = reg_value(st_reg, rd_addr);
    end
    st_next.flags = (status_rd ? (st_reg.flags & persist) : st_reg.flags) | fset;

    // Alert latch: a new alarm beats a same-cycle alert-response clear
    if (ara_rd_i && st_reg.alert) begin
      st_next.rdata = {target_addr_o, 1'b0};
      st_next.alert = 1'b0;
    end
    if (fset != 5'h00 && !st_reg.cfg[tsarc_pkg::CFG_MASK_BIT]) begin
      st_next.alert = 1'b1;
    end

    // Software reset is armed by the send and fires on the stop
    if (cmd_send_i && reg_addr_i == tsarc_pkg::CMD_SW_RESET) begin
      st_next.swrst_arm = 1'b1;
    end
    if (bus_stop_i && st_reg.swrst_arm) begin
      st_next = RST;
    end else if (bus_stop_i) begin
      st_next.swrst_arm = 1'b0;
    end
  end

  // Supply reset shares the full clear with the system reset
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || supply_por_i) begin
      st_reg <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs; alert pin is open drain, pulled low only while latched
  assign reg_rdata_o  = st_reg.rdata;
  assign ara_hit_o    = (bus_addr_i == tsarc_pkg::ARA_ADDR) && st_reg.alert;
  assign adc_start_o  = st_reg.start_p;
  assign converting_o = (st_reg.fsm == tsarc_pkg::ST_CONV);
  assign alert_o      = 1'b0;
  assign alert_oe_o   = st_reg.alert & ~st_reg.cfg[tsarc_pkg::CFG_MASK_BIT];

endmodule : tsarc_core

// File: core/tsarc_pkg.sv
// Purpose: Shared constants and helpers for the sensor control core
// Assumes: 100 MHz clock_i, synchronous active-high resets
// Notes:   Command codes double as register index values
// Behaviour
// - One shared bus address for both channels
// - Decode two tri-level straps into nine addresses
// - Sample straps only at resets, then hold
// - Also answer the alert-response address
// - Supply reset clears all volatile state
// - No conversion start while converter undervoltage
// - Send Byte FCh acts as full reset
// - New address active within 100us of stop
// - Any reset clears the alert latch
// - After reset auto-convert at 0.25Hz
// - After reset index pointer is 00h
// - Reset loads high limits max, lows min
// - Results updated within 156ms after start
// - One-shot during conversion is ignored
// - Rate change bounds next timed update
// - Decode remote, status, config, rate codes
// - Codes 0Dh/0Eh write remote limits
// - Status: open 0x04, remote alarms 0x18
// - Rate value 07h selects 8Hz
// - Idle one-shot restarts the rate timer
// - Flags sticky until reset or status read
// - Config bit 6 stops conversions immediately
package tsarc_pkg;

  // Timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned CONV_TIME_MS   = 125;
  localparam int unsigned CONV_CYCLES    = CONV_TIME_MS * CLK_PER_MS;
  localparam int unsigned SLOW_PERIOD_MS = 16000;
  localparam int unsigned SLOW_PERIOD_CYCLES = SLOW_PERIOD_MS * CLK_PER_MS;

  // Command codes
  localparam logic [7:0] CMD_LOCAL_TEMP  = 8'h00;
  localparam logic [7:0] CMD_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] CMD_STATUS      = 8'h02;
  localparam logic [7:0] CMD_CFG_RD      = 8'h03;
  localparam logic [7:0] CMD_RATE_RD     = 8'h04;
  localparam logic [7:0] CMD_LHI_RD      = 8'h05;
  localparam logic [7:0] CMD_LLO_RD      = 8'h06;
  localparam logic [7:0] CMD_RHI_RD      = 8'h07;
  localparam logic [7:0] CMD_RLO_RD      = 8'h08;
  localparam logic [7:0] CMD_CFG_WR      = 8'h09;
  localparam logic [7:0] CMD_RATE_WR     = 8'h0a;
  localparam logic [7:0] CMD_LHI_WR      = 8'h0b;
  localparam logic [7:0] CMD_LLO_WR      = 8'h0c;
  localparam logic [7:0] CMD_RHI_WR      = 8'h0d;
  localparam logic [7:0] CMD_RLO_WR      = 8'h0e;
  localparam logic [7:0] CMD_ONE_SHOT    = 8'h0f;
  localparam logic [7:0] CMD_SW_RESET    = 8'hfc;

  // Reset values and field positions
  localparam logic [7:0] POINTER_POR = 8'h00;
  localparam logic [7:0] LIMIT_MAX   = 8'h7f;
  localparam logic [7:0] LIMIT_MIN   = 8'h80;
  localparam logic [7:0] TEMP_POR    = 8'h00;
  localparam int unsigned RATE_W     = 3;
  localparam logic [RATE_W-1:0] RATE_POR = 3'h2;
  localparam int unsigned CFG_MASK_BIT = 1;
  localparam int unsigned CFG_HW_STANDBY_PIN_BIT = 0;
  localparam int unsigned CFG_POS      = 6;

  // Strap levels and address pieces
  localparam logic [1:0] LVL_LOW   = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH  = 2'h2;
  localparam logic [3:0] ADDR_HI_LOW   = 4'h3;
  localparam logic [3:0] ADDR_HI_FLOAT = 4'h5;
  localparam logic [3:0] ADDR_HI_HIGH  = 4'h9;
  localparam logic [2:0] ADDR_OFS_LOW   = 3'h0;
  localparam logic [2:0] ADDR_OFS_FLOAT = 3'h1;
  localparam logic [2:0] ADDR_OFS_HIGH  = 3'h4;
  localparam logic [6:0] ADDR_DEFAULT   = 7'h2a;
  localparam logic [6:0] ARA_ADDR       = 7'h0c;

  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_CONV = 4'b0100,
    ST_HW_STANDBY_PIN = 4'b1000
  } tsarc_state_t;

  // Signed two's complement compare, a above b
  function automatic logic tsarc_above(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) > $signed(b);
  endfunction : tsarc_above

endpackage : tsarc_pkg

// File: core/tsarc_addr_latch.sv
// Purpose: Latch strap levels into the bus address and match it
// Assumes: Straps are already resolved tri-level codes
// Notes:   Code 3 on a strap is taken as floating
module tsarc_addr_latch (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       sample_i,
  input  wire logic [1:0] sel_a_i,
  input  wire logic [1:0] sel_b_i,
  input  wire logic [6:0] bus_addr_i,
  output logic      [6:0] target_addr_o,
  output logic            addr_hit_o
);

  typedef struct packed {
    logic [6:0] addr;
  } tsarc_al_t;

  tsarc_al_t st_reg;
  tsarc_al_t st_next;

  // Map a strap level to its address offset step
  function automatic logic [2:0] lvl_step(input logic [1:0] l);
    return (l == tsarc_pkg::LVL_LOW)  ? 3'h0 :
           (l == tsarc_pkg::LVL_HIGH) ? 3'h2 : 3'h1;
  endfunction : lvl_step

  // Nine-way address decode
  function automatic logic [6:0] decode(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] hi;
    logic [2:0] ofs;
    hi  = (a == tsarc_pkg::LVL_LOW)  ? tsarc_pkg::ADDR_HI_LOW :
          (a == tsarc_pkg::LVL_HIGH) ? tsarc_pkg::ADDR_HI_HIGH : tsarc_pkg::ADDR_HI_FLOAT;
    ofs = (a == tsarc_pkg::LVL_LOW)  ? tsarc_pkg::ADDR_OFS_LOW :
          (a == tsarc_pkg::LVL_HIGH) ? tsarc_pkg::ADDR_OFS_HIGH : tsarc_pkg::ADDR_OFS_FLOAT;
    return {hi, 3'(ofs + lvl_step(b))};
  endfunction : decode

  // Straps are only looked at on the sampling strobe to keep bias off
  always_comb begin
    st_next = st_reg;
    if (sample_i) begin
      st_next.addr = decode(sel_a_i, sel_b_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_reg <= '{addr: tsarc_pkg::ADDR_DEFAULT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign target_addr_o = st_reg.addr;
  assign addr_hit_o    = (bus_addr_i == st_reg.addr);

endmodule : tsarc_addr_latch

// File: tb/tsarc_core_assertions.sv
// Purpose: Port-level timing checks for the sensor control core
// Assumes: One clock; sys_rst_i and supply_por_i both reset the core
// Notes:   Strap address may only move shortly after a reset or a stop
module tsarc_core_assertions #(
  parameter int unsigned CONV_CYC = tsarc_pkg::CONV_CYCLES
) (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic       supply_por_i,
  input wire logic       adc_uvlo_i,
  input wire logic       hw_standby_pin_n_i,
  input wire logic [6:0] bus_addr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic       cmd_send_i,
  input wire logic       recv_i,
  input wire logic       ara_rd_i,
  input wire logic       bus_stop_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [6:0] target_addr_o,
  input wire logic       addr_hit_o,
  input wire logic       adc_start_o,
  input wire logic       converting_o,
  input wire logic       alert_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i || supply_por_i);

  // Cycles since a reset or stop, saturating; straps are re-taken only then
  logic [2:0]  since_reg;
  logic [31:0] conv_cnt_reg;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || supply_por_i || bus_stop_i) begin
      since_reg <= 3'h0;
    end else if (since_reg != 3'h7) begin
      since_reg <= since_reg + 3'h1;
    end
  end

  // Length of the running conversion, restarted by each start pulse
  always_ff @(posedge clock_i) begin
    if (adc_start_o) begin
      conv_cnt_reg <= 32'h1;
    end else if (converting_o) begin
      conv_cnt_reg <= conv_cnt_reg + 32'h1;
    end
  end

  property p_hit; addr_hit_o == (bus_addr_i == target_addr_o); endproperty
  a_hit: assert property (p_hit) else $error("address match flag wrong");
  property p_hold; $changed(target_addr_o) |-> since_reg < 3'h6; endproperty
  a_hold: assert property (p_hold) else $error("address moved without reset");
  property p_uvlo; adc_uvlo_i |=> !adc_start_o; endproperty
  a_uvlo: assert property (p_uvlo) else $error("start under undervoltage");
  property p_conv; $fell(converting_o) && hw_standby_pin_n_i && !$past(reg_wr_i, 2)
    && !$past(bus_stop_i) |-> conv_cnt_reg == CONV_CYC; endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
  property p_hw_standby_pin; $fell(hw_standby_pin_n_i) |=> !converting_o; endproperty
  a_hw_standby_pin: assert property (p_hw_standby_pin) else $error("standby did not stop");
  property p_rst; $fell(sys_rst_i) |-> reg_rdata_o == 8'h00 && !alert_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_idle; !reg_rd_i && !recv_i && !ara_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_shot; converting_o && cmd_send_i && reg_addr_i == 8'h0f |=> !adc_start_o;
  endproperty
  a_shot: assert property (p_shot) else $error("busy one-shot started");
endmodule : tsarc_core_assertions

bind tsarc_core tsarc_core_assertions #(.CONV_CYC(CONV_CYC)) tsarc_core_assertions_inst (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .supply_por_i(supply_por_i),
  .adc_uvlo_i(adc_uvlo_i), .hw_standby_pin_n_i(hw_standby_pin_n_i),
  .bus_addr_i(bus_addr_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .cmd_send_i(cmd_send_i), .recv_i(recv_i), .ara_rd_i(ara_rd_i),
  .bus_stop_i(bus_stop_i), .reg_rdata_o(reg_rdata_o), .target_addr_o(target_addr_o),
  .addr_hit_o(addr_hit_o), .adc_start_o(adc_start_o), .converting_o(converting_o),
  .alert_oe_o(alert_oe_o));

// File: tb/tsarc_host_model.sv
// Purpose: Bus host issuing byte transfers, each closed by a stop
// Assumes: Strobe one cycle, read data in the cycle after it
// Notes:   Released command and data lines show the inverse value
module tsarc_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] cmd_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            send_o,
  output logic            recv_o,
  output logic            ara_o,
  output logic            stop_o
);
  int idle = 0;
  initial begin
    {cmd_o, wdata_o, wr_o, rd_o, send_o, recv_o, ara_o, stop_o} = '0;
  end

  // Kinds: 0 write, 1 read, 2 send, 3 receive, 4 alert response
  task automatic xfer(input int k, input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] q);
    repeat (idle) @(posedge clock_i);
    @(posedge clock_i);
    cmd_o   <= c;
    wdata_o <= d;
    wr_o    <= (k == 0);
    rd_o    <= (k == 1);
    send_o  <= (k == 2);
    recv_o  <= (k == 3);
    ara_o   <= (k == 4);
    @(posedge clock_i);
    {wr_o, rd_o, send_o, recv_o, ara_o} <= 5'h00;
    cmd_o   <= ~c;
    wdata_o <= ~d;
    stop_o  <= 1'b1;
    @(posedge clock_i);
    q = rdata_i;
    stop_o  <= 1'b0;
  endtask : xfer
endmodule : tsarc_host_model

// File: tb/tsarc_core_test.sv
// Purpose: Self-checking bench for the sensor control core
// Assumes: Host model makes transfers; bench plays pins and converter
// Notes:   Short conversion and period parameters keep the run brief
module tsarc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 20;
  localparam int SLOW = 4096;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %h got %h", n, e, g); fail_count++; end end
  logic       clk, rst, por, uvlo, hw_standby_pin_n, dopen, hit, ara_hit, start, conv, alert_oe;
  logic [1:0] sel_a, sel_b;
  logic [6:0] baddr, taddr;
  logic [7:0] cmd, wdata, rdata, ltemp, rtemp, q;
  logic       wr, rd, send, recv, ara, stop;
  int         fail_count = 0, num_checks = 0, seed = 12531, cyc = 0;
  int         n_starts = 0, since = 0, gap = 0, a, b, e;
  int         lim_q[$] = '{127, 128, 127, 128};

  tsarc_core #(.CONV_CYC(CONV), .SLOW_CYC(SLOW)) tsarc_core_inst (
    .clock_i(clk), .sys_rst_i(rst), .supply_por_i(por), .adc_uvlo_i(uvlo),
    .hw_standby_pin_n_i(hw_standby_pin_n), .addr_select_a_i(sel_a), .addr_select_b_i(sel_b),
    .bus_addr_i(baddr), .reg_addr_i(cmd), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .cmd_send_i(send), .recv_i(recv), .ara_rd_i(ara), .bus_stop_i(stop),
    .local_temp_i(ltemp), .remote_temp_i(rtemp), .diode_open_i(dopen),
    .reg_rdata_o(rdata), .target_addr_o(taddr), .addr_hit_o(hit), .ara_hit_o(ara_hit),
    .adc_start_o(start), .converting_o(conv), .alert_o(), .alert_oe_o(alert_oe));
  tsarc_host_model tsarc_host_model_inst (
    .clock_i(clk), .rdata_i(rdata), .cmd_o(cmd), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .send_o(send), .recv_o(recv), .ara_o(ara), .stop_o(stop));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Start spacing and a hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    since <= start ? 0 : since + 1;
    if (start === 1'b1) begin
      n_starts <= n_starts + 1;
      gap <= since + 1;
    end
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // Strap decode model: code 3 reads as floating
  function automatic int exp_addr(input int sa, input int sb);
    int hi[3] = '{3, 5, 9};
    int of[3] = '{0, 1, 4};
    sa = (sa == 3) ? 1 : sa;
    sb = (sb == 3) ? 1 : sb;
    return hi[sa] * 8 + of[sa] + sb;
  endfunction : exp_addr

  task automatic xf(input int k, input int c, input int d);
    tsarc_host_model_inst.xfer(k, c[7:0], d[7:0], q);
  endtask : xf

  task automatic rd_chk(input int c, input int ev);
    xf(1, c, 0);
    `CHK("read data", ev, q)
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wait_start(input int max);
    int n0;
    n0 = n_starts;
    for (int i = 0; i < max && n_starts == n0; i++) begin
      tick(1);
    end
    `CHK("start seen", 1, int'(n_starts != n0))
  endtask : wait_start

  task automatic do_reset(input int sa, input int sb);
    @(posedge clk);
    sel_a <= sa[1:0];
    sel_b <= sb[1:0];
    rst   <= 1'b1;
    repeat (4) @(posedge clk);
    rst   <= 1'b0;
  endtask : do_reset

  initial begin
    {rst, por, uvlo, dopen, hw_standby_pin_n} = 5'h11;
    {sel_a, sel_b, baddr} = '0;
    {ltemp, rtemp} = 16'h192d;
    // Random straps: decoded once at reset, then held
    for (int i = 0; i < 12; i++) begin
      a = {$random(seed)} % 4;
      b = {$random(seed)} % 4;
      do_reset(a, b);
      tick(3);
      `CHK("strap address", exp_addr(a, b), taddr)
      baddr <= 7'(exp_addr(a, b));
      sel_a <= 2'(a + 1);
      tick(4);
      `CHK("address hit", 1'b1, hit)
      `CHK("address held", exp_addr(a, b), taddr)
    end
    // Software reset re-takes straps and restores defaults
    xf(0, 8'h09, 8'h80);
    xf(0, 8'h0a, 8'h07);
    xf(0, 8'h0d, 8'h11);
    a = {$random(seed)} % 3;
    sel_a <= a[1:0];
    xf(2, 8'hfc, 0);
    tick(CONV + 4);
    `CHK("new address", exp_addr(a, b), taddr)
    xf(3, 0, 0);
    `CHK("pointer read", ltemp, q)
    rd_chk(8'h03, 0);
    rd_chk(8'h04, 2);
    foreach (lim_q[i]) rd_chk(5 + i, lim_q[i]);
    // Timer spacing at reset rate, then fastest rate
    wait_start(1100);
    `CHK("auto period", SLOW / 4, gap)
    xf(0, 8'h0a, {$random(seed)} & 8'hf8 | 7);
    rd_chk(8'h04, 7);
    wait_start(1100);
    wait_start(40);
    `CHK("fast period", SLOW / 128, gap)
    xf(0, 8'h0a, 2);
    // One-shot while busy is dropped; while idle it restarts the timer
    wait_start(1100);
    xf(2, 8'h0f, 0);
    wait_start(1100);
    `CHK("busy one-shot", SLOW / 4, gap)
    rtemp <= 8'($random(seed));
    tick(CONV + 10);
    e = n_starts;
    xf(2, 8'h0f, 0);
    tick(CONV + 4);
    `CHK("idle one-shot", e + 1, n_starts)
    rd_chk(8'h01, rtemp);
    wait_start(1100);
    `CHK("timer restart", SLOW / 4, gap)
    // Converter held off under undervoltage
    uvlo <= 1'b1;
    e = n_starts;
    tick(CONV + 4); // Let the running conversion end so the one-shot is held, not dropped
    xf(2, 8'h0f, 0);
    tick(30);
    `CHK("start under uvlo", e, n_starts)
    uvlo <= 1'b0;
    wait_start(5);
    // Remote high alarm: sticky, kept while true, alert answered
    e = {$random(seed)} % 127;
    rtemp <= e[7:0];
    xf(0, 8'h0d, e - 1);
    xf(0, 8'h0e, 8'h80);
    tick(CONV + 4);
    xf(2, 8'h0f, 0);
    tick(CONV + 4);
    baddr <= 7'h0c;
    tick(1);
    `CHK("alert response hit", 1'b1, ara_hit)
    xf(4, 0, 0);
    `CHK("alert answer", exp_addr(a, b) * 2, q)
    tick(2);
    `CHK("alert cleared", 1'b0, alert_oe)
    for (int i = 0; i < 4; i++) begin
      if (i == 2) xf(0, 8'h0d, 8'h7f);
      xf(1, 8'h02, 0);
      `CHK("status alarm", (i == 3) ? 0 : 8'h10, q & 8'h1c)
    end
    dopen <= 1'b1;
    xf(2, 8'h0f, 0);
    tick(CONV + 4);
    dopen <= 1'b0;
    rd_chk(8'h02, 8'h04);
    rd_chk(8'h02, 8'h00);
    // Standby by configuration bit and by pin
    xf(0, 8'h09, 8'h40);
    e = n_starts;
    tick(1100);
    `CHK("standby starts", e, n_starts)
    xf(0, 8'h09, 8'h00);
    wait_start(1100);
    hw_standby_pin_n <= 1'b0;
    tick(2);
    `CHK("pin standby", 1'b0, conv)
    hw_standby_pin_n <= 1'b1;
    wait_start(5);
    // Supply reset clears written limits; unmapped read gives zero
    xf(0, 8'h0b, 8'h22);
    por <= 1'b1;
    tick(2);
    por <= 1'b0;
    tick(3);
    rd_chk(8'h05, 8'h7f);
    rd_chk(8'h55, 0);
    print_verdict();
  end
endmodule : tsarc_core_test
